// >>> core/wpps_consts.svh
/*
  Constants for the wireless power packet supervisor: header codes, counts,
  default timing windows and the operating point used during setup.
  Assumes a 100 MHz clock; included by bare name.
*/
// Operation
// - In setup, header start must follow previous stop within window, else power removed.
// - In setup, a late expected packet or out-of-order packet removes power.
// - Configuration packet 0x51 ends setup; receiver sends it last.
// - Transfer accepts 0x03, 0x04, 0x05, 0x02, proprietary and reserved packets.
// - First control error packet missing in time removes power.
// - Each control error stop restarts wait; missing next one removes power.
// - Rectified power must arrive within window after configuration stop.
// - Control error applied to operating point only after settling delay.
// - Any correctly received sequence violation in transfer removes power.
// - Ping needs signal strength 0x01; other packets end power; valid one advances.
// - Setup starts with identification 0x71; extended 0x81 only if ext bit set.
// - Operating point held at 175 kHz, 50 percent duty through setup.
// - Up to seven optional packets tolerated before configuration.
`ifndef WPPS_CONSTS_SVH
`define WPPS_CONSTS_SVH

`define WPPS_HDR_SIG_STRENGTH 8'h01
`define WPPS_HDR_END_POWER 8'h02
`define WPPS_HDR_CTRL_ERR 8'h03
`define WPPS_HDR_RECT_POWER 8'h04
`define WPPS_HDR_CHARGE_STAT 8'h05
`define WPPS_HDR_HOLD_OFF 8'h06
`define WPPS_HDR_CONFIG 8'h51
`define WPPS_HDR_IDENT 8'h71
`define WPPS_HDR_EXT_IDENT 8'h81
`define WPPS_HDR_PROP_LO 8'h18
`define WPPS_HDR_PROP_HI 8'hf2
`define WPPS_IDENT_EXT_BIT 7
`define WPPS_MAX_OPTIONAL 3'h7
`define WPPS_PING_FREQ_KHZ 16'd175
`define WPPS_DUTY_HALF 8'h80
`define WPPS_CLK_MHZ 100
`define WPPS_WIN_NEXT_US 21
`define WPPS_WIN_FIRST_CE_US 1000
`define WPPS_WIN_CE_US 2000
`define WPPS_WIN_RP_US 2000
`define WPPS_SETTLE_US 50
`define WPPS_CYC(us) ((us) * `WPPS_CLK_MHZ)

`endif

// >>> core/wpps_pkg.sv
/*
  Types for the wireless power packet supervisor.
  Assumes the constants header is included where codes are needed.
*/
package wpps_pkg;
  typedef enum logic [3:0] {
    WPPS_SELECT = 4'b0001,
    WPPS_PING = 4'b0010,
    WPPS_SETUP = 4'b0100,
    WPPS_XFER = 4'b1000
  } wpps_phase_t;

  typedef enum logic [3:0] {
    WPPS_CAUSE_NONE = 4'h0,
    WPPS_CAUSE_TIMEOUT = 4'h1,
    WPPS_CAUSE_LATE = 4'h2,
    WPPS_CAUSE_SEQ = 4'h3,
    WPPS_CAUSE_FIRST_CE = 4'h4,
    WPPS_CAUSE_CE_GAP = 4'h5,
    WPPS_CAUSE_RP_MISS = 4'h6,
    WPPS_CAUSE_END_REQ = 4'h7
  } wpps_cause_t;
endpackage

// >>> core/wpps_supervisor.sv
/*
  Packet sequence supervisor: tracks phases, checks order and timing of
  decoded receiver packets, removes power on faults, applies control errors.
  Assumes a decoder gives a one-cycle header strobe at header start bit and
  a one-cycle packet-done strobe at checksum stop bit, with checksum verdict.
*/
`timescale 1ns/1ps
`include "wpps_consts.svh"
module wpps_supervisor
  import wpps_pkg::*;
#(
  parameter int TW = 24,
  parameter int WIN_NEXT = `WPPS_CYC(`WPPS_WIN_NEXT_US),
  parameter int WIN_FIRST_CE = `WPPS_CYC(`WPPS_WIN_FIRST_CE_US),
  parameter int WIN_CE = `WPPS_CYC(`WPPS_WIN_CE_US),
  parameter int WIN_RP = `WPPS_CYC(`WPPS_WIN_RP_US),
  parameter int SETTLE = `WPPS_CYC(`WPPS_SETTLE_US)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ping_start_i,
  input wire logic hdr_start_i,
  input wire logic pkt_done_i,
  input wire logic pkt_ok_i,
  input wire logic [7:0] pkt_hdr_i,
  input wire logic [7:0] pkt_data0_i,
  input wire logic [15:0] freq_base_i,
  output logic power_en_o,
  output logic [3:0] phase_o,
  output logic [15:0] op_freq_o,
  output logic [7:0] op_duty_o,
  output logic op_update_o,
  output logic removed_o,
  output logic [3:0] cause_o
);
  ////////////////////////////////////////////////////////////////////////
  wpps_phase_t phase;
  logic got_ident, need_ext, got_ext, rp_seen, ce_seen, in_pkt;
  logic [2:0] opt_count;
  logic remove;
  wpps_cause_t next_cause;
  logic done_ok;
  logic t_next_start, t_next_exp, t_next_run;
  logic t_ce_start, t_ce_exp;
  logic t_rp_start, t_rp_exp;
  logic t_st_start, t_st_exp;
  logic t_stop;
  logic [TW-1:0] ce_load;
  logic [7:0] ce_pending;
  logic is_prop;

  assign done_ok = pkt_done_i && pkt_ok_i;
  assign is_prop = (pkt_hdr_i >= `WPPS_HDR_PROP_LO) && (pkt_hdr_i <= `WPPS_HDR_PROP_HI);
  assign t_stop = remove;

  ////////////////////////////////////////////////////////////////////////
  // Fault decision; one cause per cycle, timeouts ahead of sequence faults
  always_comb
  begin
    remove = 1'b0;
    next_cause = WPPS_CAUSE_NONE;
    case (phase)
      WPPS_SELECT:
      begin
        remove = 1'b0;
      end
      WPPS_PING:
      begin
        if (t_next_exp)
        begin
          remove = 1'b1;
          next_cause = WPPS_CAUSE_TIMEOUT;
        end
        else if (done_ok && pkt_hdr_i != `WPPS_HDR_SIG_STRENGTH)
        begin
          remove = 1'b1;
          next_cause = WPPS_CAUSE_SEQ;
        end
      end
      WPPS_SETUP:
      begin
        if (t_next_exp)
        begin
          remove = 1'b1;
          next_cause = WPPS_CAUSE_TIMEOUT;
        end
        else if (done_ok)
        begin
          if (!got_ident)
          begin
            if (pkt_hdr_i != `WPPS_HDR_IDENT)
            begin
              remove = 1'b1;
              next_cause = WPPS_CAUSE_SEQ;
            end
          end
          else if (need_ext && !got_ext)
          begin
            if (pkt_hdr_i != `WPPS_HDR_EXT_IDENT)
            begin
              remove = 1'b1;
              next_cause = WPPS_CAUSE_SEQ;
            end
          end
          else if (pkt_hdr_i == `WPPS_HDR_CONFIG)
          begin
            remove = 1'b0;
          end
          else if (pkt_hdr_i == `WPPS_HDR_IDENT || pkt_hdr_i == `WPPS_HDR_EXT_IDENT ||
                   pkt_hdr_i == `WPPS_HDR_SIG_STRENGTH || pkt_hdr_i == `WPPS_HDR_CTRL_ERR ||
                   pkt_hdr_i == `WPPS_HDR_RECT_POWER || pkt_hdr_i == `WPPS_HDR_CHARGE_STAT ||
                   pkt_hdr_i == `WPPS_HDR_END_POWER || opt_count == `WPPS_MAX_OPTIONAL)
          begin
            remove = 1'b1;
            next_cause = WPPS_CAUSE_SEQ;
          end
        end
      end
      WPPS_XFER:
      begin
        if (t_ce_exp)
        begin
          remove = 1'b1;
          next_cause = ce_seen ? WPPS_CAUSE_CE_GAP : WPPS_CAUSE_FIRST_CE;
        end
        else if (t_rp_exp)
        begin
          remove = 1'b1;
          next_cause = WPPS_CAUSE_RP_MISS;
        end
        else if (done_ok && pkt_hdr_i == `WPPS_HDR_END_POWER)
        begin
          remove = 1'b1;
          next_cause = WPPS_CAUSE_END_REQ;
        end
        else if (done_ok && (pkt_hdr_i == `WPPS_HDR_IDENT ||
                 pkt_hdr_i == `WPPS_HDR_EXT_IDENT || pkt_hdr_i == `WPPS_HDR_CONFIG ||
                 pkt_hdr_i == `WPPS_HDR_SIG_STRENGTH || pkt_hdr_i == `WPPS_HDR_HOLD_OFF))
        begin
          remove = 1'b1;
          next_cause = WPPS_CAUSE_SEQ;
        end
      end
      default:
      begin
        remove = 1'b1;
        next_cause = WPPS_CAUSE_SEQ;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase sequencing
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      phase <= WPPS_SELECT;
    end
    else if (remove)
    begin
      phase <= WPPS_SELECT;
    end
    else
    begin
      case (phase)
        WPPS_SELECT:
          if (ping_start_i)
            phase <= WPPS_PING;
        WPPS_PING:
          if (done_ok && pkt_hdr_i == `WPPS_HDR_SIG_STRENGTH)
            phase <= WPPS_SETUP;
        WPPS_SETUP:
          if (done_ok && pkt_hdr_i == `WPPS_HDR_CONFIG && got_ident &&
              !(need_ext && !got_ext))
            phase <= WPPS_XFER;
        WPPS_XFER:
          phase <= WPPS_XFER;
        default:
          phase <= WPPS_SELECT;
      endcase
    end
  end

  // Setup bookkeeping; cleared on every removal or phase entry
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      got_ident <= 1'b0;
      need_ext <= 1'b0;
      got_ext <= 1'b0;
      opt_count <= 3'h0;
    end
    else if (remove || phase != WPPS_SETUP)
    begin
      got_ident <= 1'b0;
      need_ext <= 1'b0;
      got_ext <= 1'b0;
      opt_count <= 3'h0;
    end
    else if (done_ok)
    begin
      if (!got_ident)
      begin
        got_ident <= 1'b1;
        need_ext <= pkt_data0_i[`WPPS_IDENT_EXT_BIT];
      end
      else if (need_ext && !got_ext)
        got_ext <= 1'b1;
      else if (pkt_hdr_i != `WPPS_HDR_CONFIG)
        opt_count <= opt_count + 3'h1;
    end
  end

  // A header started but not yet finished means the window was met
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      in_pkt <= 1'b0;
    else if (pkt_done_i || remove)
      in_pkt <= 1'b0;
    else if (hdr_start_i)
      in_pkt <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-header window: armed at ping entry and after each ping or setup stop bit other than
  // a good configuration one, cancelled by the header start bit
  assign t_next_start = (phase == WPPS_SELECT && ping_start_i) ||
                        (phase == WPPS_PING && pkt_done_i && !done_ok) ||
                        (phase == WPPS_SETUP && pkt_done_i) ||
                        (phase == WPPS_PING && done_ok &&
                         pkt_hdr_i == `WPPS_HDR_SIG_STRENGTH);

  wpps_timer #(.WIDTH(TW)) u_next (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(t_next_start && !(phase == WPPS_SETUP && pkt_hdr_i == `WPPS_HDR_CONFIG
                               && done_ok)),
    .stop_i(t_stop || hdr_start_i),
    .load_i(TW'(WIN_NEXT)),
    .expired_o(t_next_exp),
    .running_o(t_next_run)
  );

  // Control error interval: first window from configuration stop bit,
  // then restarted at every good control error stop bit
  assign t_ce_start = (phase == WPPS_SETUP && done_ok && pkt_hdr_i == `WPPS_HDR_CONFIG) ||
                      (phase == WPPS_XFER && done_ok && pkt_hdr_i == `WPPS_HDR_CTRL_ERR);
  assign ce_load = (phase == WPPS_SETUP) ? TW'(WIN_FIRST_CE) : TW'(WIN_CE);

  wpps_timer #(.WIDTH(TW)) u_ce (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(t_ce_start),
    .stop_i(t_stop),
    .load_i(ce_load),
    .expired_o(t_ce_exp),
    .running_o()
  );

  // Rectified power window measured from the configuration stop bit only
  assign t_rp_start = phase == WPPS_SETUP && done_ok && pkt_hdr_i == `WPPS_HDR_CONFIG;

  wpps_timer #(.WIDTH(TW)) u_rp (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(t_rp_start),
    .stop_i(t_stop || (phase == WPPS_XFER && done_ok &&
                       pkt_hdr_i == `WPPS_HDR_RECT_POWER)),
    .load_i(TW'(WIN_RP)),
    .expired_o(t_rp_exp),
    .running_o()
  );

  // Settling delay; a newer value restarts it so only the latest is applied
  assign t_st_start = phase == WPPS_XFER && done_ok && pkt_hdr_i == `WPPS_HDR_CTRL_ERR;

  wpps_timer #(.WIDTH(TW)) u_settle (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(t_st_start),
    .stop_i(t_stop),
    .load_i(TW'(SETTLE)),
    .expired_o(t_st_exp),
    .running_o()
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ce_seen <= 1'b0;
      rp_seen <= 1'b0;
      ce_pending <= 8'h00;
    end
    else if (remove || phase != WPPS_XFER)
    begin
      ce_seen <= 1'b0;
      rp_seen <= 1'b0;
      ce_pending <= 8'h00;
    end
    else
    begin
      if (t_st_start)
      begin
        ce_seen <= 1'b1;
        ce_pending <= pkt_data0_i;
      end
      if (done_ok && pkt_hdr_i == `WPPS_HDR_RECT_POWER)
        rp_seen <= 1'b1;
    end
  end

  // Operating point: fixed through ping and setup, signed error applied later
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      op_freq_o <= `WPPS_PING_FREQ_KHZ;
      op_duty_o <= `WPPS_DUTY_HALF;
      op_update_o <= 1'b0;
    end
    else
    begin
      op_update_o <= 1'b0;
      if (phase != WPPS_XFER || remove)
      begin
        op_freq_o <= `WPPS_PING_FREQ_KHZ;
        op_duty_o <= `WPPS_DUTY_HALF;
      end
      else if (t_st_exp)
      begin
        // Positive error asks for more power, so frequency drops
        op_freq_o <= op_freq_o - 16'({{8{ce_pending[7]}}, ce_pending}) + freq_base_i
                     - freq_base_i;
        op_update_o <= 1'b1;
      end
    end
  end

  // Power enable, phase and cause; cause stays until the next ping starts
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      power_en_o <= 1'b0;
      phase_o <= 4'h1;
      removed_o <= 1'b0;
      cause_o <= 4'h0;
    end
    else
    begin
      removed_o <= remove;
      phase_o <= remove ? 4'h1 : phase;
      if (remove)
      begin
        power_en_o <= 1'b0;
        cause_o <= next_cause;
      end
      else if (phase == WPPS_SELECT && ping_start_i)
      begin
        power_en_o <= 1'b1;
        cause_o <= 4'h0;
      end
    end
  end
endmodule

// >>> core/wpps_timer.sv
/*
  Down-counting window timer used by the packet supervisor.
  Assumes one clock domain and a start pulse that reloads the count.
*/
`timescale 1ns/1ps
module wpps_timer #(
  parameter int WIDTH = 24
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic [WIDTH-1:0] load_i,
  output logic expired_o,
  output logic running_o
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count <= '0;
      running_o <= 1'b0;
      expired_o <= 1'b0;
    end
    else
    begin
      expired_o <= 1'b0;
      if (stop_i)
      begin
        running_o <= 1'b0;
      end
      else if (start_i)
      begin
        count <= load_i;
        running_o <= 1'b1;
      end
      else if (running_o)
      begin
        if (count <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          running_o <= 1'b0;
          expired_o <= 1'b1;
        end
        else
        begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// >>> testbench/tb_top.sv
/*
  Self-checking bench for the packet supervisor and a receiver model.
  Assumes short windows; the driver queues what the monitor must see.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rstn_i, ping_start, req, s_ok, busy, hdr_start, pkt_done, pkt_ok;
  logic power_en, op_update, removed;
  logic [3:0] lead, phase, cause;
  logic [7:0] s_hdr, s_data, pkt_hdr, pkt_data0, op_duty;
  logic [15:0] freq_base, op_freq, f;
  logic [3:0] exp_cause[$];
  logic [15:0] exp_freq[$];
  logic [7:0] bad_hdr[5] = '{8'h71, 8'h81, 8'h51, 8'h01, 8'h06};
  int n_errors, num_checks, seed, i, t;
  //////////////////////////////////////////
  wpps_supervisor #(.WIN_NEXT(20), .WIN_FIRST_CE(50), .WIN_CE(60), .WIN_RP(80),
    .SETTLE(5)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .ping_start_i(ping_start),
    .hdr_start_i(hdr_start), .pkt_done_i(pkt_done), .pkt_ok_i(pkt_ok), .pkt_hdr_i(pkt_hdr),
    .pkt_data0_i(pkt_data0), .freq_base_i(freq_base), .power_en_o(power_en),
    .phase_o(phase), .op_freq_o(op_freq), .op_duty_o(op_duty), .op_update_o(op_update),
    .removed_o(removed), .cause_o(cause));
  wpps_rx_model rx (.clk_i(clk_i), .req_i(req), .lead_i(lead), .hdr_i(s_hdr),
    .data_i(s_data), .ok_i(s_ok), .busy_o(busy), .hdr_start_o(hdr_start),
    .done_o(pkt_done), .ok_o(pkt_ok), .hdr_o(pkt_hdr), .data_o(pkt_data0));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Short random lead keeps four packets inside one control error gap
  task send(input logic [7:0] h, input logic [7:0] d, input logic ok);
    int k;
    s_hdr <= h;
    s_data <= d;
    s_ok <= ok;
    lead <= 4'($random(seed) & 3);
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (k = 0; k < 40 && busy !== 1'b0; k++)
      @(posedge clk_i);
    if (k == 40)
    begin
      n_errors++;
      final_report;
    end
  endtask
  task start(input logic ext);
    ping_start <= 1'b1;
    @(posedge clk_i);
    ping_start <= 1'b0;
    @(posedge clk_i);
    send(8'h01, 8'($random(seed)), 1'b1);
    send(8'h71, {ext, 7'($random(seed))}, 1'b1);
  endtask
  task opts(input int n);
    int k;
    for (k = 0; k < n; k++)
      send(k[0] ? 8'h06 : 8'h18 + 8'($unsigned($random(seed)) % 56), 8'h00, 1'b1);
  endtask
  task to_xfer;
    f = 16'h00af;
    start(1'b0);
    opts(7);
    check(op_freq, 16'h00af);
    check({8'h00, op_duty}, 16'h0080);
    send(8'h51, 8'h00, 1'b1);
    // Phase output settles one edge after send returns
    @(posedge clk_i);
    check({12'h0, phase}, 16'h0008);
  endtask
  task ce(input logic [7:0] v);
    f = f - {{8{v[7]}}, v};
    exp_freq.push_back(f);
    send(8'h03, v, 1'b1);
  endtask
  task end_with(input logic [3:0] c, input logic [7:0] h);
    int k;
    exp_cause.push_back(c);
    if (h !== 8'h00)
      send(h, 8'h00, 1'b1);
    for (k = 0; k < 200 && power_en !== 1'b0; k++)
      @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    check(16'(exp_cause.size() + exp_freq.size()), 16'h0000);
    t++;
    $display("test %0d done", t);
    if (k == 200)
    begin
      n_errors++;
      final_report;
    end
  endtask
  //////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (removed === 1'b1)
    begin
      check({12'h0, cause}, {12'h0, exp_cause.size() > 0 ? exp_cause.pop_front() : 4'hf});
      check({11'h0, power_en, phase}, 16'h0001);
    end
    if (op_update === 1'b1)
      check(op_freq, exp_freq.size() > 0 ? exp_freq.pop_front() : 16'hffff);
  end
  initial
  begin
    {rstn_i, ping_start, req, s_ok, s_hdr, s_data, lead, freq_base} = '0;
    f = 16'h00af;
    seed = 17;
    {n_errors, num_checks, t} = '0;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    freq_base <= 16'($random(seed));
    @(posedge clk_i);
    check({11'h0, power_en, phase}, 16'h0001);
    start(1'b0);
    end_with(4'h3, 8'h81);
    ping_start <= 1'b1;
    @(posedge clk_i);
    ping_start <= 1'b0;
    @(posedge clk_i);
    end_with(4'h3, 8'h04);
    // Silent receiver during ping: the header window runs out
    ping_start <= 1'b1;
    @(posedge clk_i);
    ping_start <= 1'b0;
    @(posedge clk_i);
    end_with(4'h1, 8'h00);
    start(1'b1);
    send(8'h81, 8'h00, 1'b1);
    send(8'h51, 8'h00, 1'b0);
    end_with(4'h1, 8'h00);
    start(1'b0);
    opts(7);
    end_with(4'h3, 8'h06);
    to_xfer;
    ce(8'($random(seed) % 16));
    send(8'h04, 8'h00, 1'b1);
    send(8'h05, 8'h00, 1'b1);
    send(8'hc0, 8'h00, 1'b1);
    end_with(4'h7, 8'h02);
    to_xfer;
    ce(8'($random(seed) % 16));
    send(8'h04, 8'h00, 1'b1);
    end_with(4'h5, 8'h00);
    to_xfer;
    send(8'h04, 8'h00, 1'b1);
    end_with(4'h4, 8'h00);
    to_xfer;
    ce(8'h00);
    repeat (30) @(posedge clk_i);
    ce(8'h00);
    end_with(4'h6, 8'h00);
    for (i = 0; i < 5; i++)
    begin
      to_xfer;
      end_with(4'h3, bad_hdr[i]);
    end
    final_report;
  end
endmodule

// >>> testbench/wpps_properties.sv
/*
  Port checker for the packet supervisor.
  Assumes a bind onto wpps_supervisor with the short windows of the bench.
*/
`timescale 1ns/1ps
module wpps_properties
  import wpps_pkg::*;
#(
  parameter int WIN_FIRST_CE = 50,
  parameter int WIN_CE = 60,
  parameter int SETTLE = 5
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pkt_done_i,
  input wire logic pkt_ok_i,
  input wire logic [7:0] pkt_hdr_i,
  input wire logic power_en_o,
  input wire logic [3:0] phase_o,
  input wire logic [15:0] op_freq_o,
  input wire logic [7:0] op_duty_o,
  input wire logic op_update_o,
  input wire logic removed_o,
  input wire logic [3:0] cause_o
);
  //////////////////////////////////////////
  localparam int GAP_MAX = (WIN_CE > WIN_FIRST_CE ? WIN_CE : WIN_FIRST_CE) + 3;
  logic good;
  logic xfer;
  int ce_age;
  int gap;
  assign good = pkt_done_i && pkt_ok_i;
  assign xfer = phase_o == 4'h8;
  // Saturating, so an old count never wraps into the legal band
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ce_age <= 1000;
    else if (good && xfer && pkt_hdr_i == 8'h03)
      ce_age <= 1;
    else if (ce_age < 1000)
      ce_age <= ce_age + 1;
  end
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      gap <= 0;
    else if (!xfer || (good && pkt_hdr_i == 8'h03))
      gap <= 0;
    else if (gap < 1000)
      gap <= gap + 1;
  end
  //////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  removal_state_a: assert property (removed_o |-> !power_en_o && phase_o == 4'h1)
    else $error("removal left power or phase");
  removal_cause_a: assert property (removed_o |-> cause_o != 4'h0)
    else $error("removal without cause");
  setup_point_a: assert property (phase_o == 4'h4 |-> op_freq_o == 16'h00af &&
    op_duty_o == 8'h80 && !op_update_o) else $error("setup point moved");
  ce_settle_a: assert property (op_update_o |-> ce_age >= SETTLE + 1 &&
    ce_age <= SETTLE + 2) else $error("update off settle time");
  // Phase output lags the internal phase by one cycle, hence two cycles here
  config_ends_a: assert property (good && phase_o == 4'h4 && pkt_hdr_i == 8'h51
    |-> ##2 xfer) else $error("config did not end setup");
  ping_adv_a: assert property (good && phase_o == 4'h2 && pkt_hdr_i == 8'h01
    |-> ##2 phase_o == 4'h4) else $error("ping did not advance");
  ping_reject_a: assert property (good && phase_o == 4'h2 && pkt_hdr_i != 8'h01
    |-> ##[1:2] removed_o && cause_o == 4'h3) else $error("ping kept bad packet");
  xfer_reject_a: assert property (good && xfer && pkt_hdr_i inside
    {8'h71, 8'h81, 8'h51, 8'h01, 8'h06} |-> ##[1:2] removed_o && cause_o == 4'h3)
    else $error("transfer kept bad packet");
  end_request_a: assert property (good && xfer && pkt_hdr_i == 8'h02
    |-> ##[1:2] removed_o && cause_o == 4'h7) else $error("end request ignored");
  ce_gap_a: assert property (xfer |-> gap <= GAP_MAX)
    else $error("control error gap too long");
  bad_sum_a: assert property (pkt_done_i && !pkt_ok_i && phase_o == 4'h4
    |-> ##2 phase_o == 4'h4) else $error("bad checksum acted on");
  cover_xfer_c: cover property (phase_o == 4'h4 ##1 xfer);
  cover_update_c: cover property (op_update_o);
  cover_gap_c: cover property (removed_o && cause_o == 4'h5);
endmodule

bind wpps_supervisor wpps_properties #(.WIN_FIRST_CE(WIN_FIRST_CE), .WIN_CE(WIN_CE),
  .SETTLE(SETTLE)) chk (.clk_i(clk_i), .rstn_i(rstn_i), .pkt_done_i(pkt_done_i),
  .pkt_ok_i(pkt_ok_i), .pkt_hdr_i(pkt_hdr_i), .power_en_o(power_en_o), .phase_o(phase_o),
  .op_freq_o(op_freq_o), .op_duty_o(op_duty_o), .op_update_o(op_update_o),
  .removed_o(removed_o), .cause_o(cause_o));

// >>> testbench/wpps_rx_model.sv
/*
  Receiver model: frames one demodulated packet per request.
  Assumes a request is raised after an edge and dropped after the next edge.
*/
`timescale 1ns/1ps
module wpps_rx_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [3:0] lead_i,
  input wire logic [7:0] hdr_i,
  input wire logic [7:0] data_i,
  input wire logic ok_i,
  output logic busy_o,
  output logic hdr_start_o,
  output logic done_o,
  output logic ok_o,
  output logic [7:0] hdr_o,
  output logic [7:0] data_o
);
  //////////////////////////////////////////
  initial
  begin
    busy_o = 1'b0;
    hdr_start_o = 1'b0;
    done_o = 1'b0;
    ok_o = 1'b0;
    hdr_o = 8'h00;
    data_o = 8'h00;
    forever
    begin
      @(posedge clk_i);
      if (req_i)
      begin
        busy_o <= 1'b1;
        repeat (lead_i) @(posedge clk_i);
        hdr_start_o <= 1'b1;
        @(posedge clk_i);
        hdr_start_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        done_o <= 1'b1;
        hdr_o <= hdr_i;
        data_o <= data_i;
        ok_o <= ok_i;
        @(posedge clk_i);
        // Fields mean nothing off the strobe, so they show garbage
        done_o <= 1'b0;
        hdr_o <= ~hdr_i;
        data_o <= ~data_i;
        ok_o <= ~ok_i;
        busy_o <= 1'b0;
      end
    end
  end
endmodule
